// ---- logic/timing_select_bank.v ----
// APB register bank for timing pin routing and horizontal parameters
//
// Summary of operation
// [RULE_01] 4-bit selector routes signal to pins 5-8
// [RULE_02] Pin 5 selector resets to field sync
// [RULE_03] Pin 6 selector resets to digital field
// [RULE_04] Pin 7 selector resets to ten-field identifier
// [RULE_05] Pin 8 selector resets to display enable
// [RULE_06] Bit 4 picks high drive, resets low
// [RULE_07] Software writes zero to selector bits 15-5
// [RULE_08] Software writes zero to control reserved bits
// [RULE_09] Control bit 4 stretches identifier to field
// [RULE_10] Control bit 1 takes standard from register
// [RULE_11] Six-bit host standard replaces pins, resets zero
// [RULE_12] Report clocks per line for format
// [RULE_13] Hold hsync width in clocks
// [RULE_14] Hold hsync to active start in clocks
// [RULE_15] Hold hsync to active end in clocks
// [RULE_16] Horizontal parameters writable only in standard 62
// [RULE_17] Codes 1-4 give hsync, hblank, vsync, vblank
// [RULE_18] Undefined selector code drives pin low
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "timing_select_regs.vh"
module timing_select_bank (
    // Clock and reset
    input wire ref_clk_in,
    input wire nrst_in,
    // APB slave
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire pready_out,
    output reg [31:0] prdata_out,
    output reg pslverr_out,
    // External standard pins
    input wire [5:0] standard_pins_in,
    // Timing signals from the timing core
    input wire hsync_in,
    input wire hblank_in,
    input wire vsync_in,
    input wire vblank_in,
    input wire field_sync_in,
    input wire digital_field_in,
    input wire ten_field_identifier_in,
    input wire display_enable_in,
    input wire extra_timing_in,
    input wire spare_timing_in,
    input wire [3:0] user_timing_in,
    input wire field_start_in,
    // Preset horizontal parameters of the selected standard
    input wire [15:0] preset_line_length_in,
    input wire [15:0] preset_hsync_width_in,
    input wire [15:0] preset_active_start_in,
    input wire [15:0] preset_active_end_in,
    // Timing pins and drive strength
    output wire [3:0] timing_pin_out,
    output wire [3:0] high_drive_out,
    // Format to the timing core
    output reg [5:0] video_standard_select_out,
    output reg [15:0] line_length_out,
    output reg [15:0] hsync_width_out,
    output reg [15:0] active_start_out,
    output reg [15:0] active_end_out
);

// ----------------------------------------------------------------------
// Functions
// ----------------------------------------------------------------------
// Word index of a byte address, or 7'h00 when not word aligned in range
function [6:0] word_index;
    input [11:0] addr;
    begin
        if (addr[1:0] != 2'b00 || addr[11:9] != 3'b000) begin
            word_index = 7'h00;
        end else begin
            word_index = addr[8:2];
        end
    end
endfunction

// One when the index names a register of this bank
function index_mapped;
    input [6:0] idx;
    begin
        index_mapped = (idx >= `IDX_PIN5_SELECT) &&
                       (idx <= `IDX_ACTIVE_END);
    end
endfunction

// One when the standard selects custom horizontal timing
function is_custom;
    input [5:0] std;
    begin
        is_custom = (std == `STD_CUSTOM);
    end
endfunction

// Selector register image with reserved bits read as zero
function [31:0] select_image;
    input high_drive;
    input [3:0] code;
    begin
        select_image = {27'h0, high_drive, code};
    end
endfunction

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------
reg [3:0] pin5_code;
reg [3:0] pin6_code;
reg [3:0] pin7_code;
reg [3:0] pin8_code;
reg [3:0] high_drive;
reg long_field_id_pulse;
reg host_picks_standard;
reg [5:0] host_standard;
reg [15:0] custom_line_length;
reg [15:0] custom_hsync_width;
reg [15:0] custom_active_start;
reg [15:0] custom_active_end;

// ----------------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------------
wire [6:0] idx;
wire access;
wire wr_strobe;
wire rd_strobe;
wire custom_mode;

assign idx = word_index(paddr_in);
assign access = psel_in && penable_in;
assign wr_strobe = access && pwrite_in && index_mapped(idx);
assign rd_strobe = access && !pwrite_in;
assign pready_out = 1'b1;
assign custom_mode = is_custom(video_standard_select_out);

// ----------------------------------------------------------------------
// Standard pin synchroniser
// ----------------------------------------------------------------------
reg [5:0] std_pins_meta;
reg [5:0] std_pins_sync;

always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        std_pins_meta <= 6'h00;
        std_pins_sync <= 6'h00;
    end else begin
        std_pins_meta <= standard_pins_in;
        std_pins_sync <= std_pins_meta;
    end
end

// ----------------------------------------------------------------------
// Selector registers
// ----------------------------------------------------------------------
always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        pin5_code <= `RST_PIN5_CODE; // [RULE_02]
        pin6_code <= `RST_PIN6_CODE; // [RULE_03]
        pin7_code <= `RST_PIN7_CODE; // [RULE_04]
        pin8_code <= `RST_PIN8_CODE; // [RULE_05]
        high_drive <= {4{`RST_HIGH_DRIVE}}; // [RULE_06]
    end else if (wr_strobe) begin
        // Upper bits are dropped, software keeps them zero [RULE_07]
        case (idx)
            `IDX_PIN5_SELECT: begin
                pin5_code <= pwdata_in[`SEL_CODE_MSB:`SEL_CODE_LSB];
                high_drive[0] <= pwdata_in[`SEL_HIGH_DRIVE_BIT]; // [RULE_06]
            end
            `IDX_PIN6_SELECT: begin
                pin6_code <= pwdata_in[`SEL_CODE_MSB:`SEL_CODE_LSB];
                high_drive[1] <= pwdata_in[`SEL_HIGH_DRIVE_BIT]; // [RULE_06]
            end
            `IDX_PIN7_SELECT: begin
                pin7_code <= pwdata_in[`SEL_CODE_MSB:`SEL_CODE_LSB];
                high_drive[2] <= pwdata_in[`SEL_HIGH_DRIVE_BIT]; // [RULE_06]
            end
            `IDX_PIN8_SELECT: begin
                pin8_code <= pwdata_in[`SEL_CODE_MSB:`SEL_CODE_LSB];
                high_drive[3] <= pwdata_in[`SEL_HIGH_DRIVE_BIT]; // [RULE_06]
            end
            default: pin5_code <= pin5_code;
        endcase
    end
end

assign high_drive_out = high_drive; // [RULE_06]

// ----------------------------------------------------------------------
// Video control and host standard
// ----------------------------------------------------------------------
always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        long_field_id_pulse <= `RST_LONG_FIELD_ID; // [RULE_09]
        host_picks_standard <= `RST_HOST_PICKS; // [RULE_10]
        host_standard <= `RST_HOST_STANDARD; // [RULE_11]
    end else if (wr_strobe) begin
        // Reserved control bits are dropped [RULE_08]
        if (idx == `IDX_VIDEO_CONTROL) begin
            long_field_id_pulse <= pwdata_in[`VC_LONG_FIELD_ID_BIT];
            host_picks_standard <= pwdata_in[`VC_HOST_PICKS_BIT];
        end
        if (idx == `IDX_HOST_STANDARD) begin
            host_standard <= pwdata_in[`STD_MSB:0]; // [RULE_11]
        end
    end
end

// Effective standard: register or synchronised pins
always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        video_standard_select_out <= 6'h00;
    end else if (host_picks_standard) begin
        video_standard_select_out <= host_standard; // [RULE_10] [RULE_11]
    end else begin
        video_standard_select_out <= std_pins_sync;
    end
end

// ----------------------------------------------------------------------
// Horizontal timing parameters
// ----------------------------------------------------------------------
always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        custom_line_length <= `RST_HPARAM;
        custom_hsync_width <= `RST_HPARAM;
        custom_active_start <= `RST_HPARAM;
        custom_active_end <= `RST_HPARAM;
    end else if (wr_strobe && custom_mode) begin
        // Writes in any other standard are ignored [RULE_16]
        case (idx)
            `IDX_LINE_LENGTH: begin
                custom_line_length <= pwdata_in[15:0]; // [RULE_12]
            end
            `IDX_HSYNC_WIDTH: begin
                custom_hsync_width <= pwdata_in[15:0]; // [RULE_13]
            end
            `IDX_ACTIVE_START: begin
                custom_active_start <= pwdata_in[15:0]; // [RULE_14]
            end
            `IDX_ACTIVE_END: begin
                custom_active_end <= pwdata_in[15:0]; // [RULE_15]
            end
            default: custom_line_length <= custom_line_length;
        endcase
    end
end

// Parameters in force for the selected format
always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        line_length_out <= `RST_HPARAM;
        hsync_width_out <= `RST_HPARAM;
        active_start_out <= `RST_HPARAM;
        active_end_out <= `RST_HPARAM;
    end else if (custom_mode) begin
        line_length_out <= custom_line_length; // [RULE_12]
        hsync_width_out <= custom_hsync_width; // [RULE_13]
        active_start_out <= custom_active_start; // [RULE_14]
        active_end_out <= custom_active_end; // [RULE_15]
    end else begin
        line_length_out <= preset_line_length_in; // [RULE_12]
        hsync_width_out <= preset_hsync_width_in; // [RULE_13]
        active_start_out <= preset_active_start_in; // [RULE_14]
        active_end_out <= preset_active_end_in; // [RULE_15]
    end
end

// ----------------------------------------------------------------------
// Read data and error
// ----------------------------------------------------------------------
reg [31:0] next_rdata;

always @* begin
    case (idx)
        `IDX_PIN5_SELECT: next_rdata = select_image(high_drive[0], pin5_code);
        `IDX_PIN6_SELECT: next_rdata = select_image(high_drive[1], pin6_code);
        `IDX_PIN7_SELECT: next_rdata = select_image(high_drive[2], pin7_code);
        `IDX_PIN8_SELECT: next_rdata = select_image(high_drive[3], pin8_code);
        `IDX_VIDEO_CONTROL: next_rdata = {27'h0, long_field_id_pulse, 2'b00,
            host_picks_standard, 1'b0};
        `IDX_HOST_STANDARD: next_rdata = {26'h0, host_standard};
        `IDX_LINE_LENGTH: next_rdata = {16'h0000, line_length_out};
        `IDX_HSYNC_WIDTH: next_rdata = {16'h0000, hsync_width_out};
        `IDX_ACTIVE_START: next_rdata = {16'h0000, active_start_out};
        `IDX_ACTIVE_END: next_rdata = {16'h0000, active_end_out};
        default: next_rdata = 32'h00000000;
    endcase
end

always @* begin
    if (rd_strobe) begin
        prdata_out = next_rdata;
    end else begin
        prdata_out = 32'h00000000;
    end
    pslverr_out = access && !index_mapped(idx);
end

// ----------------------------------------------------------------------
// Ten-field identifier stretch
// ----------------------------------------------------------------------
reg stretched_id;
wire ten_field_identifier;

always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        stretched_id <= 1'b0;
    end else if (ten_field_identifier_in) begin
        stretched_id <= 1'b1; // [RULE_09]
    end else if (field_start_in) begin
        stretched_id <= 1'b0;
    end
end

assign ten_field_identifier = long_field_id_pulse ?
    (stretched_id || ten_field_identifier_in) :
    ten_field_identifier_in; // [RULE_09]

// ----------------------------------------------------------------------
// Timing pin routing
// ----------------------------------------------------------------------
wire [13:0] timing_signals;

// Bit n-1 is selector code n [RULE_17]
assign timing_signals = {user_timing_in, spare_timing_in,
                         extra_timing_in, display_enable_in,
                         ten_field_identifier, digital_field_in,
                         field_sync_in, vblank_in, vsync_in,
                         hblank_in, hsync_in};

timing_pin_mux pin5_mux (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .code_in(pin5_code),
    .signals_in(timing_signals),
    .pin_out(timing_pin_out[0])
); // [RULE_01]

timing_pin_mux pin6_mux (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .code_in(pin6_code),
    .signals_in(timing_signals),
    .pin_out(timing_pin_out[1])
);

timing_pin_mux pin7_mux (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .code_in(pin7_code),
    .signals_in(timing_signals),
    .pin_out(timing_pin_out[2])
);

timing_pin_mux pin8_mux (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .code_in(pin8_code),
    .signals_in(timing_signals),
    .pin_out(timing_pin_out[3])
);

endmodule // timing_select_bank

// ---- logic/timing_select_regs.vh ----
// Register indices, field positions, reset values and codes of the bank
`ifndef TIMING_SELECT_REGS_VH
`define TIMING_SELECT_REGS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_PIN5_SELECT 7'h47
`define IDX_PIN6_SELECT 7'h48
`define IDX_PIN7_SELECT 7'h49
`define IDX_PIN8_SELECT 7'h4a
`define IDX_RESERVED_SLOT 7'h4b
`define IDX_VIDEO_CONTROL 7'h4c
`define IDX_HOST_STANDARD 7'h4d
`define IDX_LINE_LENGTH 7'h4e
`define IDX_HSYNC_WIDTH 7'h4f
`define IDX_ACTIVE_START 7'h50
`define IDX_ACTIVE_END 7'h51

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SEL_CODE_MSB 3
`define SEL_CODE_LSB 0
`define SEL_HIGH_DRIVE_BIT 4
`define VC_LONG_FIELD_ID_BIT 4
`define VC_HOST_PICKS_BIT 1
`define STD_MSB 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_PIN5_CODE 4'h5
`define RST_PIN6_CODE 4'h6
`define RST_PIN7_CODE 4'h7
`define RST_PIN8_CODE 4'h8
`define RST_HIGH_DRIVE 1'b0
`define RST_LONG_FIELD_ID 1'b0
`define RST_HOST_PICKS 1'b0
`define RST_HOST_STANDARD 6'h00
`define RST_HPARAM 16'h0000

// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define STD_CUSTOM 6'h3e
`define SEL_CODE_COUNT 14

`endif

// ---- logic/timing_pin_mux.v ----
// Selector that routes one timing signal onto one timing output pin
`timescale 1ns/1ps
module timing_pin_mux (
    // Clock and reset
    input wire ref_clk_in,
    input wire nrst_in,
    // Selection
    input wire [3:0] code_in,
    input wire [13:0] signals_in,
    // Pin
    output reg pin_out
);

// ----------------------------------------------------------------------
// Registered selection
// ----------------------------------------------------------------------
reg next_pin;

always @* begin
    // Code n picks signal bit n-1; codes 0 and 15 give a quiet low pin
    if (code_in == 4'h0 || code_in > 4'he) begin
        next_pin = 1'b0; // [RULE_18]
    end else begin
        next_pin = signals_in[code_in - 4'h1]; // [RULE_01] [RULE_17]
    end
end

always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        pin_out <= 1'b0;
    end else begin
        pin_out <= next_pin;
    end
end

endmodule // timing_pin_mux

// ---- testbench/timing_core_model.sv ----
// Timing core stand-in that feeds timing levels and preset parameters
`timescale 1ns/1ps
module timing_core_model (
    // Clock and selected standard
    input wire ref_clk_in,
    input wire [5:0] std_in,
    // Timing levels, field start and presets
    output logic [13:0] sig_out = 14'h0000,
    output logic field_start_out = 1'b0,
    output logic [63:0] preset_out
);
    // ----
    // Levels change every cycle so a stale pin shows
    // ----
    logic [15:0] lfsr = 16'hace1;
    always @(posedge ref_clk_in) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        sig_out <= lfsr[13:0];
        field_start_out <= lfsr[15] & lfsr[2];
    end
    always @* begin
        for (int k = 0; k < 4; k++)
            preset_out[16 * k +: 16] = {std_in, k[1:0], 8'h5a};
    end
endmodule // timing_core_model

// ---- testbench/timing_select_bank_props.sv ----
// Checker for the timing select register bank
`timescale 1ns/1ps
module timing_select_bank_props (
    input wire ref_clk_in,
    input wire nrst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire pready_out,
    input wire [31:0] prdata_out,
    input wire pslverr_out,
    input wire [5:0] standard_pins_in,
    input wire [15:0] preset_line_length_in,
    input wire [3:0] high_drive_out,
    input wire [5:0] video_standard_select_out,
    input wire [15:0] line_length_out
);
    // ----
    // Shadow of the host standard selection
    // ----
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    logic host_picks;
    logic [5:0] host_std;
    wire acc = psel_in && penable_in;
    wire wr = acc && pwrite_in;
    wire fixed = video_standard_select_out != 6'h3e;
    always @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            host_picks <= 1'b0;
            host_std <= 6'h00;
        end else if (wr && paddr_in == 12'h130) begin
            host_picks <= pwdata_in[1];
        end else if (wr && paddr_in == 12'h134) begin
            host_std <= pwdata_in[5:0];
        end
    end
    property p_line;
        nrst_in && fixed && $stable(video_standard_select_out) ##1 fixed
            |-> line_length_out == $past(preset_line_length_in);
    endproperty
    a_line: assert property (p_line)
        else $error("line length differs from preset");
    property p_custom;
        wr && paddr_in == 12'h138 && !fixed ##1 !fixed
            |=> line_length_out == $past(pwdata_in[15:0], 2);
    endproperty
    a_custom: assert property (p_custom)
        else $error("custom line length not taken");
    property p_drive;
        wr && paddr_in == 12'h11c |=> high_drive_out[0] == $past(pwdata_in[4]);
    endproperty
    a_drive: assert property (p_drive)
        else $error("drive bit not taken");
    property p_host;
        host_picks |=> video_standard_select_out == $past(host_std);
    endproperty
    a_host: assert property (p_host)
        else $error("standard not from register");
    property p_pins;
        !host_picks |=> video_standard_select_out == $past(standard_pins_in, 3);
    endproperty
    a_pins: assert property (p_pins)
        else $error("standard not from pins");
    property p_err;
        acc && (paddr_in[1:0] != 2'b00 || paddr_in[11:9] != 3'b000)
            |-> pslverr_out && prdata_out == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("bad address not refused");
    property p_rdy;
        acc |-> pready_out;
    endproperty
    a_rdy: assert property (p_rdy) else $error("pready low in access");
    property p_idle;
        !acc |-> prdata_out == 32'h0 && !pslverr_out;
    endproperty
    a_idle: assert property (p_idle) else $error("read bus not idle");
endmodule // timing_select_bank_props
bind timing_select_bank timing_select_bank_props u_props (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out),
    .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .standard_pins_in(standard_pins_in),
    .preset_line_length_in(preset_line_length_in),
    .high_drive_out(high_drive_out),
    .video_standard_select_out(video_standard_select_out),
    .line_length_out(line_length_out));

// ---- testbench/tb_top.sv ----
// Self-checking bench for the timing select register bank
`timescale 1ns/1ps
module tb_top;
    // ----
    // Signals and model state
    // ----
    logic ref_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [5:0] standard_pins_in = 6'h00;
    wire pready_out;
    wire pslverr_out;
    wire [31:0] prdata_out;
    wire [13:0] sig;
    wire fs;
    wire [63:0] pre;
    wire [63:0] par;
    wire [3:0] pin;
    wire [3:0] drv;
    wire [5:0] std;
    int n_errors = 0;
    int compares = 0;
    integer seed = 32'h4fae;
    logic [4:0] sel [4] = '{5'h05, 5'h06, 5'h07, 5'h08};
    logic [15:0] cust [4] = '{default: 16'h0000};
    logic long_id = 1'b0;
    logic host = 1'b0;
    logic st = 1'b0;
    logic on = 1'b0;
    logic [5:0] hstd = 6'h00;
    logic [3:0] exp_pin = 4'h0;
    logic [31:0] rd;
    logic er;
    initial forever #2.5 ref_clk_in = ~ref_clk_in;
    timing_core_model core (.ref_clk_in(ref_clk_in), .std_in(std),
        .sig_out(sig), .field_start_out(fs), .preset_out(pre));
    timing_select_bank uut (
        .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .pready_out(pready_out),
        .prdata_out(prdata_out), .pslverr_out(pslverr_out),
        .standard_pins_in(standard_pins_in), .hsync_in(sig[0]),
        .hblank_in(sig[1]), .vsync_in(sig[2]), .vblank_in(sig[3]),
        .field_sync_in(sig[4]), .digital_field_in(sig[5]),
        .ten_field_identifier_in(sig[6]), .display_enable_in(sig[7]),
        .extra_timing_in(sig[8]), .spare_timing_in(sig[9]),
        .user_timing_in(sig[13:10]), .field_start_in(fs),
        .preset_line_length_in(pre[15:0]),
        .preset_hsync_width_in(pre[31:16]),
        .preset_active_start_in(pre[47:32]),
        .preset_active_end_in(pre[63:48]),
        .timing_pin_out(pin), .high_drive_out(drv),
        .video_standard_select_out(std), .line_length_out(par[15:0]),
        .hsync_width_out(par[31:16]), .active_start_out(par[47:32]),
        .active_end_out(par[63:48]));
    // ----
    // Model, bus tasks and report
    // ----
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, want);
        end
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [5:0] eff();
        return host ? hstd : standard_pins_in;
    endfunction
    function automatic logic [31:0] exp_rd(input logic [11:0] a);
        logic [1:0] k;
        k = a[3:2] ^ 2'b10;
        if (a <= 12'h128) return {27'h0, sel[a[3:2] + 2'd1]};
        if (a == 12'h130) return {27'h0, long_id, 2'b00, host, 1'b0};
        if (a == 12'h134) return {26'h0, hstd};
        if (a < 12'h138) return 32'h0;
        if (eff() == 6'h3e) return {16'h0, cust[k]};
        return {16'h0, eff(), k, 8'h5a};
    endfunction
    function automatic logic pick(input logic [3:0] c);
        if (c == 4'h0 || c == 4'hf) return 1'b0;
        if (c == 4'h7 && long_id) return sig[6] | st;
        return sig[c - 4'h1];
    endfunction
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (pready_out !== 1'b1) begin
            n_errors++;
            print_verdict();
        end
        if (w && a[1:0] == 2'b00 && a[11:9] == 3'b000) begin
            if (a <= 12'h128) sel[a[3:2] + 2'd1] = d[4:0];
            if (a == 12'h130) long_id = d[4];
            if (a == 12'h130) host = d[1];
            if (a == 12'h134) hstd = d[5:0];
            if (a >= 12'h138 && eff() == 6'h3e)
                cust[a[3:2] ^ 2'b10] = d[15:0];
        end
        @(posedge ref_clk_in);
    endtask
    task automatic rc(input int i);
        apb(1'b0, 12'h11c + 12'(4 * i), 32'h0);
        check(rd, exp_rd(12'h11c + 12'(4 * i)));
        check(er, 1'b0);
        if (i > 6)
            check({16'h0, par[16 * (i - 7) +: 16]},
                  exp_rd(12'h11c + 12'(4 * i)));
    endtask
    always @(posedge ref_clk_in) begin
        #1;
        if (on) check(pin, exp_pin);
        if (on) check(drv, {sel[3][4], sel[2][4],
                            sel[1][4], sel[0][4]});
        for (int p = 0; p < 4; p++)
            exp_pin[p] = pick(sel[p][3:0]);
        st = nrst_in & (sig[6] | (st & ~fs));
    end
    initial begin
        repeat (12) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        @(posedge ref_clk_in);
        on = 1'b1;
        for (int i = 0; i < 5; i++)
            rc(i);
        for (int i = 5; i < 11; i++)
            rc(i);
        apb(1'b1, 12'h12c, 32'h0000001f);
        rc(4);
        apb(1'b1, 12'h31c, 32'h0000001f);
        check(er, 1'b1);
        apb(1'b0, 12'h11e, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
        rc(0);
        for (int p = 0; p < 4; p++)
            for (int c = 0; c < 16; c++) begin
                apb(1'b1, 12'h11c + 12'(4 * p),
                    {27'h0, 1'($random(seed)), 4'(c)});
                repeat (3) @(posedge ref_clk_in);
                rc(p);
            end
        for (int p = 0; p < 4; p++)
            apb(1'b1, 12'h11c + 12'(4 * p), 32'(p + 5));
        apb(1'b1, 12'h130, 32'h00000010);
        repeat (60) @(posedge ref_clk_in);
        standard_pins_in <= 6'($random(seed));
        repeat (5) @(posedge ref_clk_in);
        for (int i = 5; i < 11; i++)
            rc(i);
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 12'h134, m ? 32'h05 : 32'h3e);
            apb(1'b1, 12'h130, 32'h00000012);
            standard_pins_in <= 6'($random(seed));
            repeat (5) @(posedge ref_clk_in);
            for (int i = 7; i < 11; i++)
                apb(1'b1, 12'h11c + 12'(4 * i), {16'h0, 16'($random(seed))});
            for (int i = 5; i < 11; i++)
                rc(i);
        end
        apb(1'b1, 12'h130, 32'h0);
        repeat (5) @(posedge ref_clk_in);
        for (int i = 5; i < 11; i++)
            rc(i);
        print_verdict();
    end
endmodule // tb_top
